// >>> core/asc_host.sv
// host end: apb-programmed controller that shifts frames and captures readback
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module asc_host
  import asc_pkg::*;
#(
  parameter int HALF_CYC = LINK_HALF_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link
  asc_link_if.host link
);
  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_TAIL} asc_host_state_t;

  asc_host_state_t state;
  logic dout_s;
  logic go;
  logic keep_cs;
  logic busy;
  logic done;
  logic gain_err;
  logic [31:0] tx_lo;
  logic [7:0] tx_hi;
  logic [FRAME_BITS-1:0] tx_sh;
  logic [FRAME_BITS-1:0] rx_sh;
  logic [5:0] bit_cnt;
  logic [7:0] div;
  logic div_end;
  logic wr;

  asc_sync #(.W(1), .RST(1'b0)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(link.dout),
    .q(dout_s)
  );

  assign wr = psel & penable & pready & pwrite;
  assign div_end = div == 8'(HALF_CYC - 1);

  // ****************************************
  // apb registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= !(paddr inside {OFS_CTRL, OFS_STAT, OFS_TX_LO, OFS_TX_HI, OFS_RX_LO, OFS_RX_HI});
      case (paddr)
        OFS_CTRL: prdata <= {30'h0, keep_cs, 1'b0};
        OFS_STAT: prdata <= {29'h0, gain_err, done, busy};
        OFS_TX_LO: prdata <= tx_lo;
        OFS_TX_HI: prdata <= {24'h0, tx_hi};
        OFS_RX_LO: prdata <= rx_sh[31:0];
        OFS_RX_HI: prdata <= {24'h0, rx_sh[39:32]};
        default: prdata <= '0;
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_lo <= '0;
      tx_hi <= '0;
      keep_cs <= 1'b0;
      go <= 1'b0;
    end else begin
      go <= wr && paddr == OFS_CTRL && pwdata[CTRL_GO];
      if (wr && paddr == OFS_CTRL) begin
        keep_cs <= pwdata[CTRL_KEEP_CS];
      end
      if (wr && paddr == OFS_TX_LO) begin
        tx_lo <= pwdata;
      end
      if (wr && paddr == OFS_TX_HI) begin
        tx_hi <= pwdata[7:0];
      end
    end
  end

  // ****************************************
  // frame sequencer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= H_IDLE;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.din <= 1'b0;
      tx_sh <= '0;
      rx_sh <= '0;
      bit_cnt <= '0;
      div <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      gain_err <= 1'b0;
    end else begin
      div <= (state == H_IDLE || div_end) ? 8'h00 : div + 8'h01;
      case (state)
        H_IDLE: begin
          link.cs_n <= !keep_cs;
          if (go && tx_lo[CTL_GAIN+1]) begin
            gain_err <= 1'b1;
            done <= 1'b0;
          end else if (go) begin
            gain_err <= 1'b0;
            done <= 1'b0;
            busy <= 1'b1;
            tx_sh <= {tx_hi, tx_lo[31:1], 1'b1};
            link.din <= 1'b1;
            link.cs_n <= 1'b0;
            bit_cnt <= '0;
            state <= H_LOW;
          end
        end
        H_LOW: begin
          if (div_end) begin
            rx_sh <= {dout_s, rx_sh[FRAME_BITS-1:1]};
            link.sclk <= 1'b1;
            state <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (div_end) begin
            link.sclk <= 1'b0;
            if (bit_cnt == 6'(FRAME_BITS - 1)) begin
              state <= H_TAIL;
            end else begin
              bit_cnt <= bit_cnt + 6'h01;
              tx_sh <= {1'b0, tx_sh[FRAME_BITS-1:1]};
              link.din <= tx_sh[1];
              state <= H_LOW;
            end
          end
        end
        H_TAIL: begin
          if (div_end) begin
            link.din <= 1'b0;
            link.cs_n <= !keep_cs;
            busy <= 1'b0;
            done <= 1'b1;
            state <= H_IDLE;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end
endmodule : asc_host
`default_nettype wire

// >>> core/asc_pkg.sv
// constants, field layout and types shared by both ends of the serial config link
// Behaviour
// - third data byte: ch5 low, ch6 high
// - fourth data byte: ch7 low, ch8 high
// - attenuation code picks 29/33/36.5/40dB ceiling
// - gain 00=21dB, 01=26dB; 1x never sent
// - codes 0..9 route channel to that sum output
// - codes 10..15 tie channel to rail
// - route encoding holds for all data bytes
// - every transfer is five eight-bit bytes
// - separate serial input and output lines
// - readback follows write bit order
// - readback comes from shift chain
// - serial output always driven, no request
// - read flag skips routes, control still latched
// - host holds chip select low whole frame
// - select may stay low; start bit frames
// - any channel to any output, summed
// - frame starts at first one bit
// - control byte bit layout
// - first/second data bytes: channels 1-4
// - comes up powered down
package asc_pkg;
  // ****************************************
  // frame layout
  // ****************************************
  localparam int FRAME_BITS = 40;
  localparam int BYTE_BITS = 8;
  localparam int NUM_CH = 8;
  localparam int NUM_SUM = 10;
  localparam int ROUTE_W = 4;
  localparam int CTL_START = 0;
  localparam int CTL_WRITE = 1;
  localparam int CTL_PWR = 2;
  localparam int CTL_ATN = 3;
  localparam int CTL_MODE = 5;
  localparam int CTL_GAIN = 6;
  localparam int ROUTE_LSB = 8;
  localparam logic [3:0] ROUTE_RAIL_MIN = 4'hA;
  typedef enum logic [1:0] {ATT_29DB, ATT_33DB, ATT_36P5DB, ATT_40DB} asc_atten_t;
  typedef enum logic [1:0] {GAIN_21DB, GAIN_26DB, GAIN_BAD2, GAIN_BAD3} asc_gain_t;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic PWR_OFF_RST = 1'b1;
  localparam logic MODE_RST = 1'b0;
  localparam logic [3:0] ROUTE_RST = 4'hF;
  // ****************************************
  // timing
  // ****************************************
  localparam int PCLK_NS = 40;
  localparam int LINK_HALF_NS = 320;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS + PCLK_NS - 1) / PCLK_NS;
  // ****************************************
  // host apb map
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_TX_LO = 8'h08;
  localparam logic [7:0] OFS_TX_HI = 8'h0C;
  localparam logic [7:0] OFS_RX_LO = 8'h10;
  localparam logic [7:0] OFS_RX_HI = 8'h14;
  localparam int CTRL_GO = 0;
  localparam int CTRL_KEEP_CS = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_GAIN_ERR = 2;
endpackage : asc_pkg

// >>> core/asc_link_if.sv
// serial configuration link between host controller and device
`timescale 1ns/10ps
`default_nettype none
interface asc_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  modport dev (input cs_n, input sclk, input din, output dout);
  modport host (output cs_n, output sclk, output din, input dout);
endinterface : asc_link_if
`default_nettype wire

// >>> core/asc_sync.sv
// two flip-flop synchroniser for asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module asc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RST;
      q <= RST;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : asc_sync
`default_nettype wire

// >>> core/asc_dev.sv
// device end: frame receiver, configuration latch, readback and sum matrix
`timescale 1ns/10ps
`default_nettype none
module asc_dev
  import asc_pkg::*;
#(
  parameter int FRAME_LEN = FRAME_BITS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link
  asc_link_if.dev link,
  // configuration
  output logic power_off_bit,
  output asc_atten_t atten_range_code,
  output logic gain_comp_mode,
  output asc_gain_t post_amp_gain_code,
  output logic [NUM_CH*ROUTE_W-1:0] route,
  // sum matrix: bit o*NUM_CH+c set when channel c feeds output o
  output logic [NUM_SUM*NUM_CH-1:0] doppler_sum_outputs,
  output logic [NUM_CH-1:0] rail_tie,
  output logic gain_code_invalid
);
  typedef enum logic {ST_HUNT, ST_FRAME} asc_dev_state_t;

  logic cs_n_s;
  logic sclk_s;
  logic din_s;
  logic sclk_q;
  logic rise;
  logic fall;
  logic latch;
  logic [FRAME_LEN-1:0] chain;
  logic [FRAME_LEN-1:0] next_chain;
  logic [5:0] cnt;
  asc_dev_state_t state;

  // ****************************************
  // pin synchronisation and edge detect
  // ****************************************
  asc_sync #(.W(3), .RST(3'h4)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({link.cs_n, link.sclk, link.din}),
    .q({cs_n_s, sclk_s, din_s})
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk_s;
    end
  end

  assign rise = sclk_s & ~sclk_q;
  assign fall = ~sclk_s & sclk_q;
  assign next_chain = {din_s, chain[FRAME_LEN-1:1]};
  assign latch = rise & ~cs_n_s & (state == ST_FRAME) & (cnt == 6'(FRAME_LEN - 1));

  // ****************************************
  // shift chain and readback
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain <= '0;
    end else if (rise && !cs_n_s) begin
      chain <= next_chain;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.dout <= 1'b0;
    end else if (fall) begin
      link.dout <= chain[0];
    end
  end

  // ****************************************
  // frame counter
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_HUNT;
      cnt <= '0;
    end else if (cs_n_s) begin
      state <= ST_HUNT;
      cnt <= '0;
    end else if (rise) begin
      case (state)
        ST_HUNT: begin
          if (din_s) begin
            state <= ST_FRAME;
            cnt <= 6'h01;
          end
        end
        ST_FRAME: begin
          if (cnt == 6'(FRAME_LEN - 1)) begin
            state <= ST_HUNT;
            cnt <= '0;
          end else begin
            cnt <= cnt + 6'h01;
          end
        end
        default: begin
          state <= ST_HUNT;
          cnt <= '0;
        end
      endcase
    end
  end

  // ****************************************
  // configuration latch
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_off_bit <= PWR_OFF_RST;
      atten_range_code <= ATT_29DB;
      gain_comp_mode <= MODE_RST;
      post_amp_gain_code <= GAIN_21DB;
    end else if (latch) begin
      power_off_bit <= next_chain[CTL_PWR];
      atten_range_code <= asc_atten_t'(next_chain[CTL_ATN +: 2]);
      gain_comp_mode <= next_chain[CTL_MODE];
      post_amp_gain_code <= asc_gain_t'(next_chain[CTL_GAIN +: 2]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route <= {NUM_CH{ROUTE_RST}};
    end else if (latch && next_chain[CTL_WRITE]) begin
      route <= next_chain[ROUTE_LSB +: NUM_CH*ROUTE_W];
    end
  end

  // ****************************************
  // sum matrix
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      doppler_sum_outputs <= '0;
      rail_tie <= '1;
      gain_code_invalid <= 1'b0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        rail_tie[c] <= route[c*ROUTE_W +: ROUTE_W] >= ROUTE_RAIL_MIN;
        for (int o = 0; o < NUM_SUM; o++) begin
          doppler_sum_outputs[o*NUM_CH+c] <= route[c*ROUTE_W +: ROUTE_W] == 4'(o);
        end
      end
      gain_code_invalid <= post_amp_gain_code[1];
    end
  end
endmodule : asc_dev
`default_nettype wire

// >>> tb/asc_link_monitor.sv
// wire-level checker for the serial configuration link
`timescale 1ns/10ps
`default_nettype none
module asc_link_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout
);
  // ****************************************
  // helper state
  // ****************************************
  logic sclk_q;
  logic [8:0] fcnt;
  logic [5:0] nrise;
  logic [39:0] hist;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sclk_q <= 1'b0;
    else sclk_q <= sclk;
  end
  // rises in frame and the last forty bits sent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcnt <= '0;
      nrise <= '0;
      hist <= '0;
    end else if (sclk && !sclk_q && !cs_n) begin
      fcnt <= fcnt + 9'h001;
      hist <= {hist[38:0], din};
      if (nrise != 6'h28) nrise <= nrise + 6'h01;
    end else if (cs_n) begin
      fcnt <= '0;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  property p_idle_low; cs_n |-> !sclk; endproperty
  a_idle_low: assert property (p_idle_low) else $error("clock runs while deselected");
  property p_start; $fell(cs_n) |-> din; endproperty
  a_start: assert property (p_start) else $error("frame opens without a one");
  property p_din_hold; sclk && $past(sclk) |-> $stable(din); endproperty
  a_din_hold: assert property (p_din_hold) else $error("input data moved in high phase");
  property p_dout_hold; sclk && $past(sclk) |-> $stable(dout); endproperty
  a_dout_hold: assert property (p_dout_hold) else $error("output data moved in high phase");
  property p_high_len; $rose(sclk) |-> sclk [*8] ##1 !sclk; endproperty
  a_high_len: assert property (p_high_len) else $error("high phase length wrong");
  property p_low_len; $fell(sclk) |-> !sclk [*8]; endproperty
  a_low_len: assert property (p_low_len) else $error("low phase too short");
  property p_frame_len; $rose(cs_n) |-> fcnt != 9'h000 && fcnt % 9'h028 == 9'h000; endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame not a multiple of forty bits");
  property p_readback; $rose(sclk) && !cs_n && nrise == 6'h28 |-> dout == hist[39]; endproperty
  a_readback: assert property (p_readback) else $error("readback bit differs from chain");
  c_keep: cover property (fcnt == 9'h050);
  c_frame_end: cover property ($rose(cs_n));
  c_readback: cover property ($rose(sclk) && nrise == 6'h28);
endmodule : asc_link_monitor
`default_nettype wire

// >>> tb/asc_tb_top.sv
// self-checking bench joining host and device ends over the link
`timescale 1ns/10ps
`default_nettype none
module asc_tb_top
  import asc_pkg::*;
;
  // ****************************************
  // signals and instances
  // ****************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, last_err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, route;
  logic pready, pslverr, power_off_bit, gain_comp_mode, gain_code_invalid;
  asc_atten_t atten_range_code;
  asc_gain_t post_amp_gain_code;
  logic [79:0] doppler_sum_outputs;
  logic [7:0] rail_tie;
  logic [39:0] sent_q[$];
  int error_cnt = 0, n_compared = 0;
  int m_route[8];
  int m_pwr = 1, m_atn = 0, m_mode = 0, m_gain = 0;
  always #(PCLK_NS / 2) pclk = ~pclk;
  asc_link_if link();
  asc_host #(.HALF_CYC(8)) u_asc_host (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .link(link));
  asc_dev u_asc_dev (.pclk, .presetn, .link(link), .power_off_bit, .atten_range_code, .gain_comp_mode,
    .post_amp_gain_code, .route, .doppler_sum_outputs, .rail_tie, .gain_code_invalid);
  asc_link_monitor u_asc_link_monitor (.pclk(pclk), .presetn(presetn), .cs_n(link.cs_n), .sclk(link.sclk),
    .din(link.din), .dout(link.dout));
  // ****************************************
  // tasks
  // ****************************************
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  task automatic chk_out(input logic [79:0] got, input logic [79:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected output at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_out
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      wrap_up();
    end
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h00000000, r);
    n_compared++;
    if (r !== exp) begin
      error_cnt++;
      $display("unexpected register at %0t got %h exp %h", $time, r, exp);
    end
  endtask : chk_reg
  task automatic check_cfg();
    logic [31:0] er;
    logic [79:0] es;
    logic [7:0] et;
    for (int c = 0; c < 8; c++) begin
      er[4*c +: 4] = 4'(m_route[c]);
      et[c] = m_route[c] >= 10;
      for (int o = 0; o < 10; o++) es[o*8+c] = m_route[c] == o;
    end
    chk_out(80'({power_off_bit, gain_comp_mode}), 80'({m_pwr[0], m_mode[0]}));
    chk_out(80'(atten_range_code), 80'(m_atn[1:0]));
    chk_out(80'({gain_code_invalid, post_amp_gain_code}), 80'({m_gain[1], m_gain[1:0]}));
    chk_out(80'(route), 80'(er));
    chk_out(doppler_sum_outputs, es);
    chk_out(80'(rail_tie), 80'(et));
  endtask : check_cfg
  task automatic frame(input logic [39:0] f, input logic keep);
    logic [31:0] r;
    logic [39:0] p;
    int n;
    apb(1'b1, OFS_TX_LO, f[31:0], r);
    apb(1'b1, OFS_TX_HI, {24'h000000, f[39:32]}, r);
    apb(1'b1, OFS_CTRL, {30'h00000000, keep, 1'b1}, r);
    n = 0;
    do begin
      apb(1'b0, OFS_STAT, 32'h00000000, r);
      n++;
    end while (r[STAT_DONE] !== 1'b1 && r[STAT_GAIN_ERR] !== 1'b1 && n < 500);
    chk_out(80'(r[2:1]), f[7] ? 80'h2 : 80'h1);
    if (r[STAT_DONE] !== 1'b1 && r[STAT_GAIN_ERR] !== 1'b1) begin
      error_cnt++;
      wrap_up();
    end
    if (!f[7]) begin
      m_pwr = f[2];
      m_atn = f[4:3];
      m_mode = f[5];
      m_gain = f[7:6];
      if (f[1]) for (int c = 0; c < 8; c++) m_route[c] = f[8+4*c +: 4];
      p = sent_q.pop_front();
      chk_reg(OFS_RX_LO, p[31:0]);
      chk_reg(OFS_RX_HI, {24'h000000, p[39:32]});
      sent_q.push_back(f);
    end
  endtask : frame
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [39:0] f;
    logic [31:0] r;
    for (int c = 0; c < 8; c++) m_route[c] = 15;
    sent_q.push_back(40'h0000000000);
    void'($urandom(32'h001E));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    check_cfg();
    apb(1'b0, 8'h18, 32'h00000000, r);
    chk_out(80'({r, last_err}), 80'(33'h000000001));
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      f[39:8] = $urandom;
      f[7:0] = 8'($urandom);
      if (i < 2) for (int c = 0; c < 8; c++) f[8+4*c +: 4] = 4'(i*8+c);
      f[0] = 1'b1;
      f[1] = i != 4;
      f[4:3] = 2'(i);
      f[7] = 1'b0;
      frame(f, i == 1 || i == 2);
      check_cfg();
      $display("test frame %0d done", i);
    end
    f[7] = 1'b1;
    frame(f, 1'b0);
    check_cfg();
    $display("test gain refusal done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    m_pwr = 1;
    m_atn = 0;
    m_mode = 0;
    m_gain = 0;
    for (int c = 0; c < 8; c++) m_route[c] = 15;
    sent_q.delete();
    sent_q.push_back(40'h0000000000);
    check_cfg();
    f[7] = 1'b0;
    frame(f, 1'b0);
    check_cfg();
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule : asc_tb_top
`default_nettype wire
